// >>> hw/scx_channel.sv
// Smart-card channel: receive time-out, parity NACK and transmit repeat.
// Assumes i_bit_tick pulses once per bit period, mid-bit for sampling.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module scx_channel
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	// Bit-period tick
	input  wire logic        i_bit_tick,
	// Register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	// Interrupt
	output logic             o_irq,
	// Open-drain data line
	input  wire logic        i_io,
	output logic             o_io,
	output logic             o_io_oe_n
);
	typedef struct packed {
		scx_pkg::scx_rx_t rx;
		logic [3:0]       rx_cnt;
		logic [7:0]       rx_sh;
		logic             rx_char;
		scx_pkg::scx_tx_t tx;
		logic [3:0]       tx_cnt;
		logic [9:0]       tx_sh;
		logic [7:0]       tx_data;
		logic             tx_pend;
		logic             nack;
		logic [2:0]       iter;
		logic             drive_low;
		logic             suppress;
		logic [2:0]       max_iter;
		logic [15:0]      limit;
		logic [4:0]       sts;
		logic [4:0]       mask;
		logic [7:0]       err_cnt;
		logic [7:0]       rhr;
		logic [31:0]      rdata;
	} scx_chan_state_t;

	scx_chan_state_t st_reg;
	scx_chan_state_t st_next;
	scx_to_if        to_bus ();
	logic            par_bad;
	logic            wr_ctrl;

	scx_idle_timer u_timer
	(
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.bus      (to_bus)
	);

	assign wr_ctrl           = i_wr && i_addr == scx_pkg::ADDR_CTRL;
	assign to_bus.tick       = i_bit_tick;
	assign to_bus.rx_char    = st_reg.rx_char;
	assign to_bus.wait_cmd   = wr_ctrl && i_wdata[scx_pkg::CTRL_WAIT_BIT];
	assign to_bus.reload_cmd = wr_ctrl && i_wdata[scx_pkg::CTRL_RELOAD_BIT];
	assign to_bus.limit      = st_reg.limit;
	assign par_bad           = ^{st_reg.rx_sh, i_io};

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb
	begin
		st_next         = st_reg;
		st_next.rx_char = 1'b0;
		st_next.rdata   = 32'h0000_0000;
		// Writes come first so that hardware events below win
		if (i_wr)
		begin
			case (i_addr)
				scx_pkg::ADDR_CTRL:
					if (i_wdata[scx_pkg::CTRL_CLRREP_BIT])
						st_next.sts[scx_pkg::ST_ITER] = 1'b0;
				scx_pkg::ADDR_MODE:
				begin
					st_next.suppress = i_wdata[scx_pkg::MODE_SUPP_BIT];
					st_next.max_iter = i_wdata[scx_pkg::MODE_ITER_LSB +: 3];
				end
				scx_pkg::ADDR_LIMIT:  st_next.limit = i_wdata[15:0];
				scx_pkg::ADDR_MASK:   st_next.mask  = i_wdata[4:0];
				scx_pkg::ADDR_TXDATA:
					// Ignored while a character is still in flight
					if (!st_reg.tx_pend && st_reg.tx == scx_pkg::TX_IDLE)
					begin
						st_next.tx_data = i_wdata[7:0];
						st_next.tx_pend = 1'b1;
					end
				default: ;
			endcase
		end
		if (i_rd)
		begin
			case (i_addr)
				scx_pkg::ADDR_MODE:
					st_next.rdata = {25'h0, st_reg.max_iter, 3'h0, st_reg.suppress};
				scx_pkg::ADDR_LIMIT:  st_next.rdata = {16'h0000, st_reg.limit};
				scx_pkg::ADDR_STATUS:
				begin
					st_next.rdata = {27'h0, st_reg.sts};
					st_next.sts   = st_reg.sts & scx_pkg::KEEP_ON_READ;
				end
				scx_pkg::ADDR_MASK:   st_next.rdata = {27'h0, st_reg.mask};
				scx_pkg::ADDR_ERRCNT:
				begin
					st_next.rdata   = {24'h0, st_reg.err_cnt};
					st_next.err_cnt = 8'h00;
				end
				scx_pkg::ADDR_RXDATA: st_next.rdata = {24'h0, st_reg.rhr};
				default: ;
			endcase
		end
		// Time-out events
		if (to_bus.expired)
			st_next.sts[scx_pkg::ST_TIMEOUT] = 1'b1;
		if (st_reg.limit == 16'h0000)
			st_next.sts[scx_pkg::ST_TIMEOUT] = 1'b0;
		// --------------------------------------------------------
		// Receiver
		// --------------------------------------------------------
		case (st_reg.rx)
			scx_pkg::RX_IDLE:
				if (i_bit_tick && !i_io && st_reg.tx == scx_pkg::TX_IDLE)
				begin
					st_next.rx     = scx_pkg::RX_DATA;
					st_next.rx_cnt = 4'h0;
				end
			scx_pkg::RX_DATA:
				if (i_bit_tick)
				begin
					st_next.rx_sh  = {i_io, st_reg.rx_sh[7:1]};
					st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
					if (st_reg.rx_cnt == scx_pkg::RX_LAST_DATA)
						st_next.rx = scx_pkg::RX_PAR;
				end
			scx_pkg::RX_PAR:
				if (i_bit_tick)
				begin
					st_next.rx_char = 1'b1;
					st_next.rx      = scx_pkg::RX_GUARD;
					if (par_bad && st_next.err_cnt != scx_pkg::ERR_MAX)
						st_next.err_cnt = st_next.err_cnt + 8'h01;
					if (par_bad && !st_reg.suppress)
					begin
						st_next.sts[scx_pkg::ST_PARITY_ERROR_FLAG] = 1'b1;
						st_next.drive_low             = 1'b1;
						st_next.rx                    = scx_pkg::RX_NACK;
					end
					else
					begin
						st_next.rhr                    = st_reg.rx_sh;
						st_next.sts[scx_pkg::ST_RX_READY_FLAG] = 1'b1;
					end
				end
			scx_pkg::RX_NACK:
				// Error bit adds one bit time before the guard bit
				if (i_bit_tick)
				begin
					st_next.drive_low = 1'b0;
					st_next.rx        = scx_pkg::RX_GUARD;
				end
			scx_pkg::RX_GUARD:
				if (i_bit_tick)
					st_next.rx = scx_pkg::RX_IDLE;
			default: st_next.rx = scx_pkg::RX_IDLE;
		endcase
		// --------------------------------------------------------
		// Transmitter
		// --------------------------------------------------------
		case (st_reg.tx)
			scx_pkg::TX_IDLE:
				if (st_reg.tx_pend && st_reg.rx == scx_pkg::RX_IDLE)
				begin
					st_next.tx      = scx_pkg::TX_RUN;
					st_next.tx_pend = 1'b0;
					st_next.tx_cnt  = 4'h0;
					st_next.tx_sh   = {^st_reg.tx_data, st_reg.tx_data, 1'b0};
				end
			scx_pkg::TX_RUN:
				if (i_bit_tick)
				begin
					st_next.tx_cnt = st_reg.tx_cnt + 4'h1;
					if (st_reg.tx_cnt <= scx_pkg::TX_LAST_BIT)
					begin
						st_next.drive_low = !st_reg.tx_sh[0];
						st_next.tx_sh     = {1'b1, st_reg.tx_sh[9:1]};
					end
					else if (st_reg.tx_cnt == scx_pkg::TX_RELEASE)
						st_next.drive_low = 1'b0;
					else if (st_reg.tx_cnt == scx_pkg::TX_SAMPLE)
						st_next.nack = !i_io;
					else if (st_reg.nack && st_reg.iter < st_reg.max_iter)
					begin
						// 3-bit limit caps a character at eight sends
						st_next.iter   = st_reg.iter + 3'h1;
						st_next.tx_cnt = 4'h0;
						st_next.tx_sh  = {^st_reg.tx_data, st_reg.tx_data, 1'b0};
						if (st_reg.iter + 3'h1 == st_reg.max_iter)
							st_next.sts[scx_pkg::ST_ITER] = 1'b1;
					end
					else
					begin
						st_next.iter                    = scx_pkg::ITER_RESET;
						st_next.tx                      = scx_pkg::TX_IDLE;
						st_next.sts[scx_pkg::ST_TXDONE] = 1'b1;
					end
				end
			default: st_next.tx = scx_pkg::TX_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			st_reg          <= '0;
			st_reg.rx       <= scx_pkg::RX_IDLE;
			st_reg.tx       <= scx_pkg::TX_IDLE;
			st_reg.limit    <= scx_pkg::LIMIT_RESET;
			st_reg.sts      <= scx_pkg::STATUS_RESET;
			st_reg.mask     <= scx_pkg::MASK_RESET;
			st_reg.iter     <= scx_pkg::ITER_RESET;
			st_reg.max_iter <= scx_pkg::ITER_RESET;
		end
		else
			st_reg <= st_next;
	end

	assign o_rdata   = st_reg.rdata;
	assign o_irq     = |(st_reg.sts & st_reg.mask);
	assign o_io      = 1'b0;
	assign o_io_oe_n = !st_reg.drive_low;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	sequence s_par_bad;
		st_reg.rx == scx_pkg::RX_PAR && i_bit_tick && par_bad;
	endsequence
	sequence s_tx_end;
		st_reg.tx == scx_pkg::TX_RUN && i_bit_tick && st_reg.tx_cnt > scx_pkg::TX_SAMPLE;
	endsequence

	a_nack_drive: assert property (s_par_bad and !st_reg.suppress |=>
		!o_io_oe_n ##1 (!o_io_oe_n || st_reg.rx == scx_pkg::RX_GUARD))
		else $error("no NACK after parity error");
	a_bad_dropped: assert property (s_par_bad and !st_reg.suppress |=>
		$stable(st_reg.rhr) && st_reg.sts[scx_pkg::ST_PARITY_ERROR_FLAG])
		else $error("bad char stored or flag missing");
	a_supp_quiet: assert property (s_par_bad and st_reg.suppress |=>
		o_io_oe_n [*2])
		else $error("error driven while suppressed");
	a_supp_store: assert property (s_par_bad and st_reg.suppress |=>
		st_reg.sts[scx_pkg::ST_RX_READY_FLAG] && st_reg.rhr == $past(st_reg.rx_sh))
		else $error("suppressed char not stored");
	a_err_read: assert property (i_rd && i_addr == scx_pkg::ADDR_ERRCNT &&
		!(st_reg.rx == scx_pkg::RX_PAR && i_bit_tick) |=> st_reg.err_cnt == 8'h00)
		else $error("error tally not cleared by read");
	a_err_sat: assert property (st_reg.err_cnt == scx_pkg::ERR_MAX &&
		!(i_rd && i_addr == scx_pkg::ADDR_ERRCNT) |=> st_reg.err_cnt == scx_pkg::ERR_MAX)
		else $error("error tally wrapped");
	a_repeat_nack: assert property (s_tx_end and st_reg.nack &&
		st_reg.iter < st_reg.max_iter |=> st_reg.tx_cnt == 4'h0 &&
		st_reg.iter == $past(st_reg.iter) + 3'h1)
		else $error("character not repeated after NACK");
	a_repeat_flag: assert property (s_tx_end and st_reg.nack &&
		st_reg.iter + 3'h1 == st_reg.max_iter |=> st_reg.sts[scx_pkg::ST_ITER])
		else $error("repeat limit flag not set");
	a_ack_stops: assert property (s_tx_end and !st_reg.nack |=>
		st_reg.iter == 3'h0 && st_reg.tx == scx_pkg::TX_IDLE)
		else $error("repeat not stopped on ack");
	a_clr_repeat: assert property (wr_ctrl && i_wdata[scx_pkg::CTRL_CLRREP_BIT] &&
		!(st_reg.tx == scx_pkg::TX_RUN && i_bit_tick) |=> !st_reg.sts[scx_pkg::ST_ITER])
		else $error("repeat flag not cleared");
	a_timeout_flag: assert property (to_bus.expired && st_reg.limit != 16'h0000 |=>
		st_reg.sts[scx_pkg::ST_TIMEOUT])
		else $error("time-out flag not set");
endmodule // scx_channel

// >>> hw/scx_idle_timer.sv
// Receive idle time-out down-counter.
// Assumes commands and character events are one-cycle pulses.
`timescale 1ns/1ps
module scx_idle_timer
(
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_arst_n,
	// Channel side
	scx_to_if.tmr     bus
);
	typedef struct packed {
		scx_pkg::scx_to_t state;
		logic [15:0]      count;
		logic             expired;
	} scx_tmr_state_t;

	scx_tmr_state_t st_reg;
	scx_tmr_state_t st_next;

	always_comb
	begin
		st_next         = st_reg;
		st_next.expired = 1'b0;
		if (bus.limit == 16'h0000)
		begin
			st_next.state = scx_pkg::TO_WAIT;
			st_next.count = 16'h0000;
		end
		else if (bus.reload_cmd)
		begin
			st_next.state = scx_pkg::TO_RUN;
			st_next.count = bus.limit;
		end
		else if (bus.wait_cmd)
		begin
			st_next.state = scx_pkg::TO_WAIT;
			st_next.count = bus.limit;
		end
		else if (bus.rx_char && st_reg.state != scx_pkg::TO_DONE)
		begin
			st_next.state = scx_pkg::TO_RUN;
			st_next.count = bus.limit;
		end
		else if (st_reg.state == scx_pkg::TO_RUN && bus.tick)
		begin
			st_next.count = st_reg.count - 16'h0001;
			if (st_reg.count <= 16'h0001)
			begin
				st_next.count   = 16'h0000;
				st_next.expired = 1'b1;
				st_next.state   = scx_pkg::TO_DONE;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			st_reg <= '{scx_pkg::TO_WAIT, 16'h0000, 1'b0};
		else
			st_reg <= st_next;
	end

	assign bus.expired = st_reg.expired;
	assign bus.count   = st_reg.count;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	a_zero_disables: assert property (bus.limit == 16'h0000 |=> !bus.expired)
		else $error("time-out fired with zero limit");
	a_reload_runs: assert property (bus.reload_cmd && bus.limit != 16'h0000 |=>
		st_reg.state == scx_pkg::TO_RUN && bus.count == $past(bus.limit))
		else $error("reload did not start count");
	a_expiry_flag: assert property (st_reg.state == scx_pkg::TO_RUN && bus.tick &&
		bus.count == 16'h0001 && !bus.reload_cmd && !bus.wait_cmd && !bus.rx_char &&
		bus.limit != 16'h0000 |=> bus.expired ##1 !bus.expired)
		else $error("expiry pulse wrong");
	a_wait_quiet: assert property (st_reg.state == scx_pkg::TO_WAIT && !bus.reload_cmd &&
		!bus.rx_char |=> !bus.expired)
		else $error("time-out while waiting first char");
	a_done_holds: assert property (st_reg.state == scx_pkg::TO_DONE && !bus.reload_cmd &&
		!bus.wait_cmd && bus.limit != 16'h0000 |=>
		st_reg.state == scx_pkg::TO_DONE && bus.count == 16'h0000)
		else $error("counter left stop state alone");
endmodule // scx_idle_timer

// >>> inc/scx_pkg.sv
// Constants, register map and state types of the smart-card channel.
// Assumes a single 10 MHz clock and a synchronous bit-period tick.
package scx_pkg;
	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_MODE   = 8'h04;
	localparam logic [7:0] ADDR_LIMIT  = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_MASK   = 8'h10;
	localparam logic [7:0] ADDR_ERRCNT = 8'h14;
	localparam logic [7:0] ADDR_TXDATA = 8'h18;
	localparam logic [7:0] ADDR_RXDATA = 8'h1c;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_WAIT_BIT   = 0;
	localparam int CTRL_RELOAD_BIT = 1;
	localparam int CTRL_CLRREP_BIT = 2;
	localparam int MODE_SUPP_BIT   = 0;
	localparam int MODE_ITER_LSB   = 4;
	localparam int ST_RX_READY_FLAG        = 0;
	localparam int ST_PARITY_ERROR_FLAG         = 1;
	localparam int ST_TIMEOUT      = 2;
	localparam int ST_ITER         = 3;
	localparam int ST_TXDONE       = 4;
	localparam int ST_W            = 5;
	// ------------------------------------------------------------
	// Reset values and counts
	// ------------------------------------------------------------
	localparam logic [ST_W-1:0] STATUS_RESET = 5'h00;
	localparam logic [ST_W-1:0] MASK_RESET   = 5'h00;
	localparam logic [ST_W-1:0] KEEP_ON_READ = 5'h08;
	localparam logic [15:0]     LIMIT_RESET  = 16'h0000;
	localparam logic [2:0]      ITER_RESET   = 3'h0;
	localparam logic [7:0]      ERR_MAX      = 8'hff;
	localparam logic [3:0]      RX_LAST_DATA = 4'h7;
	localparam logic [3:0]      TX_LAST_BIT  = 4'h9;
	localparam logic [3:0]      TX_RELEASE   = 4'ha;
	localparam logic [3:0]      TX_SAMPLE    = 4'hb;
	// ------------------------------------------------------------
	// State types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {RX_IDLE, RX_DATA, RX_PAR, RX_NACK, RX_GUARD} scx_rx_t;
	typedef enum logic [0:0] {TX_IDLE, TX_RUN} scx_tx_t;
	typedef enum logic [1:0] {TO_WAIT, TO_RUN, TO_DONE} scx_to_t;
endpackage

// >>> inc/scx_to_if.sv
// Link between the channel and its idle time-out counter.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface scx_to_if;
	logic        tick;
	logic        rx_char;
	logic        wait_cmd;
	logic        reload_cmd;
	logic [15:0] limit;
	logic        expired;
	logic [15:0] count;
	modport ctl (output tick, rx_char, wait_cmd, reload_cmd, limit, input expired, count);
	modport tmr (input tick, rx_char, wait_cmd, reload_cmd, limit, output expired, count);
endinterface

// >>> verification/scx_card_model.sv
// Behavioural smart card on the open-drain data line.
// Assumes the bench resolves the wire and supplies the bit tick.
`timescale 1ns/1ps
module scx_card_model
(
	// Clock and bit tick
	input  wire logic i_clk,
	input  wire logic i_tick,
	// Data line
	input  wire logic i_line,
	output logic      o_oe_n
);
	logic       tx_oe_n   = 1'b1;
	logic       nack_oe_n = 1'b1;
	logic       sending   = 1'b0;
	logic [7:0] shreg     = 8'h00;
	logic [7:0] got       = 8'h00;
	int         cnt       = 0;
	int         sends     = 0;
	int         nacks_left = 0;
	assign o_oe_n = tx_oe_n & nack_oe_n;
	// ----------------------------------------
	// Listener: captures device characters
	// ----------------------------------------
	always @(posedge i_clk)
	begin
		if (i_tick && !sending)
		begin
			if (cnt == 0)
			begin
				if (i_line === 1'b0)
				begin
					cnt <= 1;
					sends <= sends + 1;
				end
			end
			else
			begin
				// Data follows the start tick directly, as the receiver samples it
				if (cnt >= 1 && cnt <= 8)
					shreg <= {i_line, shreg[7:1]};
				if (cnt == 9)
					got <= shreg;
				// NACK must stand before the sender samples one tick after release
				nack_oe_n <= !(cnt == 9 && nacks_left > 0);
				if (cnt == 9 && nacks_left > 0)
					nacks_left <= nacks_left - 1;
				cnt <= (cnt == 11) ? 0 : cnt + 1;
			end
		end
	end
	// ----------------------------------------
	// Sender: start, data LSB first, even parity
	// ----------------------------------------
	task automatic send_char(input logic [7:0] d, input logic bad);
		logic [10:0] bits;
		bits = {1'b1, (^d) ^ bad, d, 1'b0};
		sending <= 1'b1;
		for (int i = 0; i < 11; i++)
		begin
			@(posedge i_clk iff i_tick);
			tx_oe_n <= bits[i];
		end
		// Guard time covers a NACK from the device
		repeat (2) @(posedge i_clk iff i_tick);
		sending <= 1'b0;
	endtask
endmodule // scx_card_model

// >>> verification/usart_rx_timeout_and_smartcard_errors_tb_top.sv
// Self-checking bench for the smart-card channel.
// Assumes the card model drives the open-drain line with a pull-up.
`timescale 1ns/1ps
module usart_rx_timeout_and_smartcard_errors_tb_top;
	localparam int TD = 4;
	localparam int TL = 12;
	logic        i_clk      = 1'b0;
	logic        i_arst_n   = 1'b0;
	logic        i_bit_tick = 1'b0;
	logic [7:0]  i_addr     = 8'h00;
	logic [31:0] i_wdata    = 32'h0;
	logic        i_wr       = 1'b0;
	logic        i_rd       = 1'b0;
	logic [31:0] o_rdata;
	logic        o_irq;
	logic        o_io;
	logic        o_io_oe_n;
	logic        card_oe_n;
	logic        rd_pend    = 1'b0;
	logic [7:0]  b;
	logic [31:0] w;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [7:0]  rst_a[9] = '{scx_pkg::ADDR_CTRL, scx_pkg::ADDR_MODE, scx_pkg::ADDR_LIMIT,
		scx_pkg::ADDR_STATUS, scx_pkg::ADDR_MASK, scx_pkg::ADDR_ERRCNT,
		scx_pkg::ADDR_TXDATA, scx_pkg::ADDR_RXDATA, 8'h20};
	logic [2:0]  lims[3]    = '{3'h0, 3'h3, 3'h7};
	int          nks[3]     = '{1, 2, 20};
	int          miscompares = 0;
	int          tests_run  = 0;
	int          cyc        = 0;
	int          tdiv       = 0;
	int          nack_clks  = 0;
	int          n;
	// Wire-AND with pull-up
	wire         line = o_io_oe_n & card_oe_n;

	scx_channel u_dut (
		.i_clk     (i_clk),
		.i_arst_n  (i_arst_n),
		.i_bit_tick(i_bit_tick),
		.i_addr    (i_addr),
		.i_wdata   (i_wdata),
		.i_wr      (i_wr),
		.i_rd      (i_rd),
		.o_rdata   (o_rdata),
		.o_irq     (o_irq),
		.i_io      (line),
		.o_io      (o_io),
		.o_io_oe_n (o_io_oe_n)
	);
	scx_card_model u_card (
		.i_clk (i_clk),
		.i_tick(i_bit_tick),
		.i_line(line),
		.o_oe_n(card_oe_n)
	);

	always #50 i_clk = ~i_clk;
	// ----------------------------------------
	// Bit tick, cycle limit, NACK clock count
	// ----------------------------------------
	always @(posedge i_clk)
	begin
		tdiv <= (tdiv == TD - 1) ? 0 : tdiv + 1;
		i_bit_tick <= (tdiv == TD - 1);
		cyc <= cyc + 1;
		if (o_io_oe_n === 1'b0)
			nack_clks <= nack_clks + 1;
		if (cyc == 40000)
		begin
			miscompares++;
			end_of_test();
		end
	end
	// ----------------------------------------
	// Read watcher: oldest note against read data
	// ----------------------------------------
	always @(posedge i_clk)
	begin
		rd_pend <= i_rd;
		if (rd_pend)
			check("rdata", o_rdata & msk_q.pop_front(), exp_q.pop_front());
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		tests_run++;
		if (seen !== ex)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic ticks(input int k);
		repeat (k) @(posedge i_clk iff i_bit_tick);
	endtask
	task automatic rx_case(input logic [7:0] d, input logic bad, input int nk);
		int n0;
		n0 = nack_clks;
		u_card.send_char(d, bad);
		check("nack clocks", nack_clks - n0, nk);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		void'($urandom(55214));
		repeat (10) @(posedge i_clk);
		i_arst_n <= 1'b1;
		@(posedge i_clk);
		foreach (rst_a[i]) reg_rd(rst_a[i], 32'h0, '1);
		w = $urandom();
		reg_wr(scx_pkg::ADDR_MODE, w);
		reg_rd(scx_pkg::ADDR_MODE, w & 32'h71, '1);
		reg_wr(scx_pkg::ADDR_LIMIT, w);
		reg_rd(scx_pkg::ADDR_LIMIT, w & 32'hffff, '1);
		reg_wr(8'h24, w);
		reg_rd(8'h24, 32'h0, '1);
		reg_wr(scx_pkg::ADDR_LIMIT, 32'h0);
		reg_wr(scx_pkg::ADDR_MODE, 32'h0);
		// Good character, then interrupt unmasked and cleared
		b = $urandom();
		rx_case(b, 1'b0, 0);
		check("irq", {31'h0, o_irq}, 32'h0);
		reg_wr(scx_pkg::ADDR_MASK, 32'h1);
		check("irq", {31'h0, o_irq}, 32'h1);
		reg_rd(scx_pkg::ADDR_RXDATA, b, '1);
		reg_rd(scx_pkg::ADDR_STATUS, 32'h1, '1);
		check("irq", {31'h0, o_irq}, 32'h0);
		reg_wr(scx_pkg::ADDR_MASK, 32'h0);
		rx_case(~b, 1'b1, TD);
		reg_rd(scx_pkg::ADDR_RXDATA, b, '1);
		reg_rd(scx_pkg::ADDR_STATUS, 32'h2, '1);
		reg_rd(scx_pkg::ADDR_ERRCNT, 32'h1, '1);
		reg_rd(scx_pkg::ADDR_ERRCNT, 32'h0, '1);
		// Suppressed rejects run the tally past saturation
		reg_wr(scx_pkg::ADDR_MODE, 32'h1);
		for (int i = 0; i < 257; i++)
		begin
			b = $urandom();
			rx_case(b, 1'b1, 0);
		end
		reg_rd(scx_pkg::ADDR_RXDATA, b, '1);
		reg_rd(scx_pkg::ADDR_STATUS, 32'h1, '1);
		reg_rd(scx_pkg::ADDR_ERRCNT, 32'hff, '1);
		// Transmit with repeat limits 0, 3 and 7
		reg_wr(scx_pkg::ADDR_MASK, 32'h10);
		foreach (lims[i])
		begin
			b = $urandom();
			u_card.nacks_left = nks[i];
			u_card.sends = 0;
			reg_wr(scx_pkg::ADDR_MODE, {25'h0, lims[i], 4'h0});
			reg_wr(scx_pkg::ADDR_TXDATA, {24'h0, b});
			n = 0;
			while (o_irq !== 1'b1 && n < 2000)
			begin
				@(posedge i_clk);
				n++;
			end
			check("sends", u_card.sends, (nks[i] < lims[i] ? nks[i] : lims[i]) + 1);
			check("wire byte", {24'h0, u_card.got}, {24'h0, b});
			check("io level", {31'h0, o_io}, 32'h0);
			w = (lims[i] != 0 && nks[i] >= lims[i]) ? 32'h18 : 32'h10;
			reg_rd(scx_pkg::ADDR_STATUS, w, 32'h18);
			reg_rd(scx_pkg::ADDR_STATUS, w, 32'h08);
			reg_wr(scx_pkg::ADDR_CTRL, 32'h4);
			reg_rd(scx_pkg::ADDR_STATUS, 32'h0, '1);
		end
		u_card.nacks_left = 0;
		// Idle time-out
		reg_wr(scx_pkg::ADDR_MASK, 32'h4);
		reg_wr(scx_pkg::ADDR_CTRL, 32'h2);
		ticks(40);
		reg_rd(scx_pkg::ADDR_STATUS, 32'h0, '1);
		reg_wr(scx_pkg::ADDR_LIMIT, TL);
		reg_wr(scx_pkg::ADDR_CTRL, 32'h2);
		ticks(TL - 2);
		check("irq", {31'h0, o_irq}, 32'h0);
		ticks(3);
		check("irq", {31'h0, o_irq}, 32'h1);
		reg_rd(scx_pkg::ADDR_STATUS, 32'h4, '1);
		ticks(3 * TL);
		reg_rd(scx_pkg::ADDR_STATUS, 32'h0, '1);
		reg_wr(scx_pkg::ADDR_CTRL, 32'h1);
		ticks(3 * TL);
		reg_rd(scx_pkg::ADDR_STATUS, 32'h0, '1);
		rx_case(8'h5a, 1'b0, 0);
		ticks(TL - 4);
		check("irq", {31'h0, o_irq}, 32'h0);
		ticks(5);
		reg_rd(scx_pkg::ADDR_STATUS, 32'h5, '1);
		repeat (4) @(posedge i_clk);
		end_of_test();
	end
endmodule // usart_rx_timeout_and_smartcard_errors_tb_top
